// ---- sli_pkg.sv ----
/*
 Constants, register map and state type for the front-panel status lamp logic.
 Assumes a single 100 MHz core clock and a test sequencer inside the same chip.
*/
package sli_pkg;
    localparam int CODE_W = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int EV_W   = 3;
    localparam int LVL_W  = 2;
    localparam int NET_N  = 2;
    localparam int PORT_N = 4;

    typedef enum logic [1:0] {ST_TEST, ST_FAULT, ST_OPER} sli_state_type;

    localparam logic PHASE_SETUP = 1'b0;
    localparam logic PHASE_MEM   = 1'b1;

    localparam logic [CODE_W-1:0] CODE_RST = 4'h0;

    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_EVENT  = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h8;

    localparam int ST_CODE_LSB  = 0;
    localparam int ST_PHASE_BIT = 4;
    localparam int ST_STATE_LSB = 8;
    localparam int ST_NFAIL_BIT = 12;

    localparam int EV_STEP  = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_PASS  = 2;

    localparam logic [EV_W-1:0]   EV_RST     = 3'h0;
    localparam logic [EV_W-1:0]   MASK_RST   = 3'h0;
    localparam logic [LVL_W-1:0]  LVL_MAX    = 2'h3;
    localparam logic [DATA_W-1:0] RDATA_NONE = 32'h0;
endpackage : sli_pkg

// ---- sli_top.sv ----
/*
 Status lamp driver: self-test progress display, fault freeze, module-good
 lamp and operational lamp states, with a small register port and interrupt.
 Assumes sequencer and network inputs are synchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sli_top #(
    parameter int BLINK_W = 24                                     // Flash divider width
) (
    input  wire logic                       core_clk,          // 100 MHz clock
    input  wire logic                       rst_n,             // Async reset, low
    input  wire logic                       clk_en,            // Freezes state when low
    input  wire logic [sli_pkg::ADDR_W-1:0] reg_addr,          // Register byte address
    input  wire logic [sli_pkg::DATA_W-1:0] reg_wdata,         // Write data
    input  wire logic                       reg_wr,            // Write strobe
    input  wire logic                       reg_rd,            // Read strobe
    output logic      [sli_pkg::DATA_W-1:0] reg_rdata,         // Read data, next cycle
    output logic                            irq,               // Level interrupt
    input  wire logic                       seq_step,          // New step code pulse
    input  wire logic                       seq_phase,         // 0 setup, 1 memory
    input  wire logic [sli_pkg::CODE_W-1:0] seq_code,          // Step number
    input  wire logic                       seq_fault,         // Hardware fault pulse
    input  wire logic                       seq_pass,          // Test passed pulse
    input  wire logic                       nonfatal_fail,     // Non-fatal failure level
    input  wire logic [sli_pkg::NET_N-1:0]  net_link,          // Port on working LAN
    input  wire logic [sli_pkg::NET_N-1:0]  net_port_bad,      // Port hardware failed
    input  wire logic [sli_pkg::NET_N-1:0]  net_standby,       // Backup or mgmt off
    input  wire logic [sli_pkg::NET_N-1:0]  act_pulse,         // One pulse per frame
    input  wire logic [sli_pkg::NET_N-1:0]  act_back,          // Connected via back
    input  wire logic [sli_pkg::PORT_N-1:0] serial_ok,         // Serial port normal
    input  wire logic [sli_pkg::PORT_N-1:0] serial_mgmt_off,   // Serial mgmt disabled
    input  wire logic [sli_pkg::PORT_N-1:0] isdn_ok,           // ISDN port normal
    input  wire logic [sli_pkg::PORT_N-1:0] isdn_mgmt_off,     // ISDN mgmt disabled
    output logic                            led_power,         // Power lamp
    output logic                            led_mod_ok,        // Module-good lamp
    output logic      [sli_pkg::NET_N-1:0]  led_net_grn,       // Lamps 1,2 green
    output logic      [sli_pkg::NET_N-1:0]  led_net_amb,       // Lamps 1,2 amber
    output logic      [sli_pkg::PORT_N-1:0] led_port,          // Lamps 3..6, [3]=lamp 3
    output logic      [sli_pkg::NET_N-1:0]  led_act_grn,       // Activity green
    output logic      [sli_pkg::NET_N-1:0]  led_act_yel,       // Activity yellow
    output logic      [sli_pkg::PORT_N-1:0] led_isdn           // Lamps 7..10
);
    // Activity flash needs counter bits down to BLINK_W-5
    if (BLINK_W < 6) begin : g_blink_chk
        $error("BLINK_W too small for four flash rates");
    end

    logic                       rst_meta_r;
    logic                       rst_sync_n;
    sli_pkg::sli_state_type     st_r;
    logic                       phase_r;
    logic [sli_pkg::CODE_W-1:0] code_r;
    logic [sli_pkg::EV_W-1:0]   ev_r;
    logic [sli_pkg::EV_W-1:0]   mask_r;
    logic [sli_pkg::EV_W-1:0]   ev_set;
    logic [BLINK_W-1:0]         blink_cnt_r;
    logic [sli_pkg::LVL_W-1:0]  tcnt_r [sli_pkg::NET_N];
    logic [sli_pkg::LVL_W-1:0]  lvl_r  [sli_pkg::NET_N];
    logic                       win_end;
    logic                       slow_blink;
    logic                       ev_rd;

    logic                       mod_ok_nxt;
    logic [sli_pkg::NET_N-1:0]  net_grn_nxt;
    logic [sli_pkg::NET_N-1:0]  net_amb_nxt;
    logic [sli_pkg::PORT_N-1:0] port_nxt;
    logic [sli_pkg::NET_N-1:0]  act_grn_nxt;
    logic [sli_pkg::NET_N-1:0]  act_yel_nxt;
    logic [sli_pkg::PORT_N-1:0] isdn_nxt;

    // Lamp is lit steadily, or follows the blink phase when flashing
    function automatic logic lamp(input logic on, input logic flash, input logic blink);
        lamp = on & (~flash | blink);
    endfunction : lamp

    // Faster flash for higher traffic level
    function automatic logic act_blink(input logic [BLINK_W-1:0] cnt, input logic [sli_pkg::LVL_W-1:0] lvl);
        act_blink = cnt[BLINK_W - 2 - int'(lvl)];
    endfunction : act_blink

    // Reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // Test sequence state
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r <= sli_pkg::ST_TEST;
        end else if (clk_en) begin
            case (st_r)
                sli_pkg::ST_TEST: begin
                    if (seq_fault) begin
                        st_r <= sli_pkg::ST_FAULT;
                    end else if (seq_pass) begin
                        st_r <= sli_pkg::ST_OPER;
                    end
                end
                sli_pkg::ST_FAULT: st_r <= sli_pkg::ST_FAULT;
                sli_pkg::ST_OPER:  st_r <= sli_pkg::ST_OPER;
                default:           st_r <= sli_pkg::ST_TEST;
            endcase
        end
    end

    // Progress code, frozen outside the test state
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phase_r <= sli_pkg::PHASE_SETUP;
            code_r  <= sli_pkg::CODE_RST;
        end else if (clk_en && st_r == sli_pkg::ST_TEST && seq_step && !seq_fault && !seq_pass) begin
            phase_r <= seq_phase;
            code_r  <= seq_code;
        end
    end

    // Blink base and traffic level per activity lamp
    assign win_end    = &blink_cnt_r;
    assign slow_blink = blink_cnt_r[BLINK_W-1];

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            blink_cnt_r <= '0;
        end else if (clk_en) begin
            blink_cnt_r <= blink_cnt_r + 1'b1;
        end
    end

    for (genvar i = 0; i < sli_pkg::NET_N; i++) begin : g_traffic
        always_ff @(posedge core_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                tcnt_r[i] <= '0;
                lvl_r[i]  <= '0;
            end else if (clk_en) begin
                if (win_end) begin
                    lvl_r[i]  <= tcnt_r[i];
                    tcnt_r[i] <= {{(sli_pkg::LVL_W-1){1'b0}}, act_pulse[i]};
                end else if (act_pulse[i] && tcnt_r[i] != sli_pkg::LVL_MAX) begin
                    tcnt_r[i] <= tcnt_r[i] + 1'b1;
                end
            end
        end
    end

    // Lamp pattern for the present state
    always_comb begin
        mod_ok_nxt  = 1'b0;
        net_grn_nxt = '0;
        net_amb_nxt = '0;
        port_nxt    = '0;
        act_grn_nxt = '0;
        act_yel_nxt = '0;
        isdn_nxt    = '0;
        case (st_r)
            sli_pkg::ST_TEST: begin
                if (phase_r == sli_pkg::PHASE_MEM) begin
                    net_grn_nxt = 2'h2;
                end else if (code_r != sli_pkg::CODE_RST) begin
                    net_grn_nxt = 2'h1;
                end
                port_nxt = code_r;
            end
            sli_pkg::ST_FAULT: begin
                if (phase_r == sli_pkg::PHASE_MEM) begin
                    net_amb_nxt = 2'h2;
                end else if (code_r != sli_pkg::CODE_RST) begin
                    net_amb_nxt = 2'h1;
                end
                port_nxt = code_r;
            end
            sli_pkg::ST_OPER: begin
                mod_ok_nxt = lamp(1'b1, nonfatal_fail, slow_blink);
                for (int i = 0; i < sli_pkg::NET_N; i++) begin
                    net_amb_nxt[i] = net_port_bad[i];
                    net_grn_nxt[i] = !net_port_bad[i] &&
                                     lamp(net_link[i] | net_standby[i], net_standby[i], slow_blink);
                    act_grn_nxt[i] = !act_back[i] &&
                                     lamp(net_link[i], lvl_r[i] != '0, act_blink(blink_cnt_r, lvl_r[i]));
                    act_yel_nxt[i] = act_back[i] &&
                                     lamp(net_link[i], lvl_r[i] != '0, act_blink(blink_cnt_r, lvl_r[i]));
                end
                for (int i = 0; i < sli_pkg::PORT_N; i++) begin
                    port_nxt[i] = lamp(serial_ok[i] | serial_mgmt_off[i], serial_mgmt_off[i], slow_blink);
                    isdn_nxt[i] = lamp(isdn_ok[i] | isdn_mgmt_off[i], isdn_mgmt_off[i], slow_blink);
                end
            end
            default: begin
                mod_ok_nxt = 1'b0;
            end
        endcase
    end

    // Registered lamp drivers
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            led_power   <= 1'b0;
            led_mod_ok  <= 1'b0;
            led_net_grn <= '0;
            led_net_amb <= '0;
            led_port    <= '0;
            led_act_grn <= '0;
            led_act_yel <= '0;
            led_isdn    <= '0;
        end else if (clk_en) begin
            led_power   <= 1'b1;
            led_mod_ok  <= mod_ok_nxt;
            led_net_grn <= net_grn_nxt;
            led_net_amb <= net_amb_nxt;
            led_port    <= port_nxt;
            led_act_grn <= act_grn_nxt;
            led_act_yel <= act_yel_nxt;
            led_isdn    <= isdn_nxt;
        end
    end

    // Sticky events, set wins over the clearing read
    assign ev_rd = reg_rd && reg_addr == sli_pkg::ADDR_EVENT;

    always_comb begin
        ev_set = '0;
        if (st_r == sli_pkg::ST_TEST) begin
            ev_set[sli_pkg::EV_FAULT] = seq_fault;
            ev_set[sli_pkg::EV_PASS]  = seq_pass && !seq_fault;
            ev_set[sli_pkg::EV_STEP]  = seq_step && !seq_fault && !seq_pass;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ev_r <= sli_pkg::EV_RST;
        end else if (clk_en) begin
            ev_r <= (ev_rd ? '0 : ev_r) | ev_set;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mask_r <= sli_pkg::MASK_RST;
        end else if (clk_en && reg_wr && reg_addr == sli_pkg::ADDR_MASK) begin
            mask_r <= reg_wdata[sli_pkg::EV_W-1:0];
        end
    end

    assign irq = |(ev_r & mask_r);

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= sli_pkg::RDATA_NONE;
        end else if (clk_en) begin
            reg_rdata <= sli_pkg::RDATA_NONE;
            if (reg_rd) begin
                case (reg_addr)
                    sli_pkg::ADDR_STATUS: begin
                        reg_rdata[sli_pkg::ST_CODE_LSB +: sli_pkg::CODE_W] <= code_r;
                        reg_rdata[sli_pkg::ST_PHASE_BIT]                   <= phase_r;
                        reg_rdata[sli_pkg::ST_STATE_LSB +: 2]              <= st_r;
                        reg_rdata[sli_pkg::ST_NFAIL_BIT]                   <= nonfatal_fail;
                    end
                    sli_pkg::ADDR_EVENT: reg_rdata[sli_pkg::EV_W-1:0] <= ev_r;
                    sli_pkg::ADDR_MASK:  reg_rdata[sli_pkg::EV_W-1:0] <= mask_r;
                    default:             reg_rdata <= sli_pkg::RDATA_NONE;
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    a_test_on_reset: assert property (
        $rose(rst_sync_n) |-> st_r == sli_pkg::ST_TEST)
        else $error("not in test after reset");
    a_step_taken: assert property (
        clk_en && st_r == sli_pkg::ST_TEST && seq_step && !seq_fault && !seq_pass
        |=> code_r == $past(seq_code) ##1 !$past(clk_en) || led_port == $past(seq_code, 2))
        else $error("step code not shown");
    a_pass_lights_ok: assert property (
        clk_en && st_r == sli_pkg::ST_TEST && seq_pass && !seq_fault
        |=> st_r == sli_pkg::ST_OPER ##1 (!$past(clk_en) || nonfatal_fail || $past(nonfatal_fail) || led_mod_ok))
        else $error("module-good not lit after pass");
    a_oper_sticky: assert property (
        st_r == sli_pkg::ST_OPER |=> st_r == sli_pkg::ST_OPER)
        else $error("left operational state");
    a_oper_ports: assert property (
        clk_en && st_r == sli_pkg::ST_OPER && serial_ok == 4'hf && serial_mgmt_off == 4'h0
        |=> led_port == 4'hf)
        else $error("serial lamps not operational");
    a_modok_off_test: assert property (
        clk_en && st_r != sli_pkg::ST_OPER |=> !led_mod_ok)
        else $error("module-good lit during test");
    a_first_step_dark: assert property (
        clk_en && st_r == sli_pkg::ST_TEST && phase_r == sli_pkg::PHASE_SETUP && code_r == sli_pkg::CODE_RST
        |=> led_port == 4'h0 && led_net_grn == 2'h0 && led_power)
        else $error("first step lamps not dark");
    a_setup_code: assert property (
        clk_en && st_r == sli_pkg::ST_TEST && phase_r == sli_pkg::PHASE_SETUP && code_r != sli_pkg::CODE_RST
        |=> led_net_grn == 2'h1 && led_port == $past(code_r))
        else $error("setup phase display wrong");
    a_mem_code: assert property (
        clk_en && st_r == sli_pkg::ST_TEST && phase_r == sli_pkg::PHASE_MEM
        |=> led_net_grn == 2'h2 && led_port == $past(code_r))
        else $error("memory phase display wrong");
    a_fault_freeze: assert property (
        st_r == sli_pkg::ST_FAULT |=> $stable(code_r) && $stable(phase_r))
        else $error("code moved after fault");
    a_fault_amber: assert property (
        clk_en && st_r == sli_pkg::ST_FAULT |=> led_net_grn == 2'h0 && led_port == $past(code_r) &&
        (led_net_amb != 2'h0 || $past(phase_r) == sli_pkg::PHASE_SETUP && $past(code_r) == sli_pkg::CODE_RST))
        else $error("fault lamps not amber");
    a_unused_dark: assert property (
        clk_en && st_r != sli_pkg::ST_OPER |=> led_isdn == 4'h0 && led_act_grn == 2'h0 && led_act_yel == 2'h0)
        else $error("unused lamps lit in test");
    a_one_colour: assert property (
        (led_act_grn & led_act_yel) == 2'h0 && (led_net_grn & led_net_amb) == 2'h0)
        else $error("two colours at once");
    a_fail_ok_off: assert property (
        st_r == sli_pkg::ST_FAULT |=> !led_mod_ok [*4])
        else $error("module-good lit after failure");
    a_back_yellow: assert property (
        clk_en && st_r == sli_pkg::ST_OPER && act_back[0] |=> !led_act_grn[0])
        else $error("back connection shown green");
    a_irq_level: assert property (
        clk_en && (ev_set & mask_r) != '0 && !(reg_wr && reg_addr == sli_pkg::ADDR_MASK) |=> irq)
        else $error("unmasked event did not raise interrupt");
    a_read_clears: assert property (
        clk_en && ev_rd && ev_set == '0 |=> ev_r == '0)
        else $error("event register not cleared by read");

    c_pass: cover property (st_r == sli_pkg::ST_TEST ##1 st_r == sli_pkg::ST_OPER);
    c_fault_mem: cover property (st_r == sli_pkg::ST_FAULT && phase_r == sli_pkg::PHASE_MEM);
    c_nonfatal: cover property (st_r == sli_pkg::ST_OPER && nonfatal_fail ##1 !led_mod_ok);
    c_irq_read: cover property (irq && ev_rd ##1 !irq);
endmodule : sli_top
`default_nettype wire

// ---- tb_top.sv ----
/*
 Self-checking bench for the status lamp driver: progress table, fault freeze,
 register port, interrupt, clock enable and operational lamps.
 Assumes sli_pkg and sli_top are compiled first; one 100 MHz clock, no partner.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int BW = 6;
    logic        core_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1;
    logic [3:0]  reg_addr = 4'h0, seq_code = 4'h0;
    logic [31:0] reg_wdata = 32'h0, rd_v;
    logic        reg_wr = 1'h0, reg_rd = 1'h0, seq_step = 1'h0, seq_phase = 1'h0;
    logic        seq_fault = 1'h0, seq_pass = 1'h0, nonfatal_fail = 1'h0;
    logic [1:0]  net_link = 2'h0, net_port_bad = 2'h0, net_standby = 2'h0, act_pulse = 2'h0, act_back = 2'h0;
    logic [3:0]  serial_ok = 4'h0, serial_mgmt_off = 4'h0, isdn_ok = 4'h0, isdn_mgmt_off = 4'h0;
    logic [31:0] reg_rdata;
    logic        irq, led_power, led_mod_ok;
    logic [1:0]  led_net_grn, led_net_amb, led_act_grn, led_act_yel;
    logic [3:0]  led_port, led_isdn;
    int          failures = 0, comparisons = 0, hi_a, hi_b, hi_c;
    logic [10:0] rows [7] = '{{1'h0, 4'h0, 2'h0, 4'h0}, {1'h0, 4'h1, 2'h1, 4'h1}, {1'h0, 4'h5, 2'h1, 4'h5},
                              {1'h0, 4'hc, 2'h1, 4'hc}, {1'h1, 4'h1, 2'h2, 4'h1}, {1'h1, 4'h6, 2'h2, 4'h6},
                              {1'h1, 4'hb, 2'h2, 4'hb}};

    sli_top #(.BLINK_W(BW)) sli_top_inst (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .seq_step(seq_step),
        .seq_phase(seq_phase), .seq_code(seq_code), .seq_fault(seq_fault), .seq_pass(seq_pass),
        .nonfatal_fail(nonfatal_fail), .net_link(net_link), .net_port_bad(net_port_bad),
        .net_standby(net_standby), .act_pulse(act_pulse), .act_back(act_back), .serial_ok(serial_ok),
        .serial_mgmt_off(serial_mgmt_off), .isdn_ok(isdn_ok), .isdn_mgmt_off(isdn_mgmt_off),
        .led_power(led_power), .led_mod_ok(led_mod_ok), .led_net_grn(led_net_grn), .led_net_amb(led_net_amb),
        .led_port(led_port), .led_act_grn(led_act_grn), .led_act_yel(led_act_yel), .led_isdn(led_isdn));

    always #5 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic do_reset();
        @(posedge core_clk);
        rst_n <= 1'h0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk({led_power, led_mod_ok, led_port, led_net_grn, irq}, 32'h0);
        @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk({led_power, led_mod_ok, led_net_grn, led_net_amb, led_port}, 32'h200);
    endtask : do_reset

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'h1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        @(negedge core_clk);
        rd_v = reg_rdata;
    endtask : rd

    task automatic step(input logic ph, input logic [3:0] c);
        @(posedge core_clk);
        seq_step <= 1'h1; seq_phase <= ph; seq_code <= c;
        @(posedge core_clk);
        seq_step <= 1'h0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask : step

    // Lit cycles counted over four slow flash periods
    task automatic flash();
        hi_a = 0; hi_b = 0; hi_c = 0;
        repeat (4 << BW) begin
            @(negedge core_clk);
            hi_a += int'(led_mod_ok);
            hi_b += int'(led_port[0]);
            hi_c += int'(led_act_yel[0]);
        end
    endtask : flash

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        stop_test();
    end

    initial begin
        do_reset();
        foreach (rows[i]) begin
            step(rows[i][10], rows[i][9:6]);
            chk({led_net_grn, led_net_amb, led_port}, {rows[i][5:4], 2'h0, rows[i][3:0]});
            chk({led_mod_ok, led_act_grn, led_act_yel, led_isdn}, 32'h0);
        end
        @(posedge core_clk);
        clk_en <= 1'h0;
        step(1'h1, 4'h3);
        chk(led_port, 4'hb);
        @(posedge core_clk);
        clk_en <= 1'h1;
        seq_fault <= 1'h1;
        @(posedge core_clk);
        seq_fault <= 1'h0;
        step(1'h1, 4'h4);
        chk({led_net_grn, led_net_amb, led_port, led_mod_ok}, {2'h0, 2'h2, 4'hb, 1'h0});
        rd(4'h0); chk(rd_v, 32'h11b);
        wr(4'h8, 32'h2); rd(4'h8); chk(rd_v, 32'h2);
        @(negedge core_clk); chk(irq, 1'h1);
        rd(4'h4); chk(rd_v, 32'h3); chk(irq, 1'h0);
        rd(4'h4); chk(rd_v, 32'h0);
        rd(4'hc); chk(rd_v, 32'h0);
        do_reset();
        wr(4'h8, 32'h4);
        step(1'h0, 4'h3);
        chk({led_mod_ok, irq}, 2'h0);
        @(posedge core_clk);
        net_link <= 2'h1; net_port_bad <= 2'h2; act_back <= 2'h1;
        serial_ok <= 4'h8; serial_mgmt_off <= 4'h1; isdn_ok <= 4'h5;
        seq_pass <= 1'h1;
        @(posedge core_clk);
        seq_pass <= 1'h0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk({led_power, led_mod_ok, irq}, 3'h7);
        chk({led_net_grn[0], led_net_amb[1], led_act_yel[0], led_act_grn[0]}, 4'he);
        chk({led_isdn, led_port[3]}, 5'hb);
        flash();
        chk({hi_a == (4 << BW), hi_b > 0, hi_b < (4 << BW), hi_c == (4 << BW)}, 4'hf);
        @(posedge core_clk);
        nonfatal_fail <= 1'h1;
        act_pulse <= 2'h1;
        flash();
        chk({hi_a > 0, hi_a < (4 << BW), hi_c > 0, hi_c < (4 << BW)}, 4'hf);
        step(1'h0, 4'h7);
        chk(led_isdn, 4'h5);
        chk(led_port[3:1], 3'h4);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
